// ==== hdl/video_io_pkg.sv ====
// Package for the host-visible video I/O register set.
// Assumes an 8-bit processor I/O bus with a 10-bit port address.
package video_io_pkg;
  localparam int ADDR_W = 10;
  localparam logic [9:0] PORT_TC_INDEX = 10'h3d4;
  localparam logic [9:0] PORT_TC_DATA = 10'h3d5;
  localparam logic [9:0] PORT_MODE = 10'h3d8;
  localparam logic [9:0] PORT_COLOUR = 10'h3d9;
  localparam logic [9:0] PORT_STATUS = 10'h3da;
  localparam logic [9:0] PORT_PEN_CLEAR = 10'h3db;
  localparam logic [9:0] PORT_PEN_SET = 10'h3dc;
  // Timing controller register count and index width
  localparam int TC_REG_COUNT = 18;
  localparam int TC_INDEX_W = 5;
  // Mode register fields
  localparam int MODE_PIXEL_CLOCK = 0;
  localparam int MODE_GRAPHICS = 1;
  localparam int MODE_MONO = 2;
  localparam int MODE_VIDEO_ON = 3;
  localparam int MODE_WIDE = 4;
  localparam int MODE_BLINK = 5;
  // Colour-select fields
  localparam int COL_BLUE = 0;
  localparam int COL_GREEN = 1;
  localparam int COL_RED = 2;
  localparam int COL_INTENSITY = 3;
  localparam int COL_BACK_INT = 4;
  localparam int COL_PALETTE = 5;
  // Status fields
  localparam int STAT_INACTIVE = 0;
  localparam int STAT_PEN_TRIG = 1;
  localparam int STAT_PEN_SW = 2;
  localparam int STAT_VRETRACE = 3;
  // Pin bus order, synchroniser depth and the idle level of each pin
  localparam int PIN_RETRACE = 0;
  localparam int PIN_ACTIVE = 1;
  localparam int PIN_SWITCH = 2;
  localparam int PIN_PEN = 3;
  localparam int PIN_COUNT = 4;
  localparam int SYNC_STAGES = 3;
  localparam logic [3:0] PIN_IDLE = 4'h4; // Open pen switch reads high
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] STATUS_RESERVED = 8'hf0;
endpackage

// ==== hdl/video_host_io_registers.sv ====
// Host-visible video I/O registers: timing controller index and data,
// mode, colour select, status, and light-pen latch strobes.
// Status bits 7:4 read as ones; writes to unmapped ports are ignored.
// Assumes bus strobes are one-cycle pulses on mclk; pen inputs are async.
`timescale 1ns/10ps
`default_nettype none

module video_host_io_registers
  import video_io_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic vretrace_in,
  input wire logic display_active_in,
  input wire logic pen_switch_n,
  input wire logic pen_in,
  output logic [TC_INDEX_W-1:0] tc_index,
  output logic tc_write,
  output logic [7:0] tc_wdata,
  output logic pen_strobe,
  output logic [7:0] array_index,
  output logic attr_blink_select,
  output logic wide_graphics_select,
  output logic display_output_on,
  output logic mono_colour_select,
  output logic graphics_mode_select,
  output logic pixel_clock_speed_select,
  output logic palette_set_select,
  output logic back_fore_intensity,
  output logic border_intensity_select,
  output logic border_red_select,
  output logic border_green_select,
  output logic border_blue_select
);

  // Pin synchronisers. Each pin passes three flops and its filtered level
  // only moves once the second and third stages agree, so a pin that changes
  // close to a clock edge cannot make a status bit flicker for one cycle.
  // The price is three to four cycles of latency, far below a line time.
  wire logic [PIN_COUNT-1:0] pin_raw;
  wire logic [PIN_COUNT-1:0] pin_clean;
  logic vr_q;
  logic da_q;
  logic sw_q;
  logic pen_q;

  // Pin bus in the bit order given by the package
  assign pin_raw[PIN_RETRACE] = vretrace_in;
  assign pin_raw[PIN_ACTIVE] = display_active_in;
  assign pin_raw[PIN_SWITCH] = pen_switch_n;
  assign pin_raw[PIN_PEN] = pen_in;

  // One identical synchroniser per pin
  for (genvar p = 0; p < PIN_COUNT; p++) begin : gen_pin_sync
    logic [SYNC_STAGES-1:0] stage;
    logic [SYNC_STAGES-1:0] next_stage;
    logic clean;
    logic next_clean;

    // Shift the pin in; the filtered level waits for the last two to agree
    always_comb begin
      next_stage = {stage[SYNC_STAGES-2:0], pin_raw[p]};
      next_clean = clean;
      if (stage[SYNC_STAGES-2] == stage[SYNC_STAGES-1]) begin
        next_clean = stage[SYNC_STAGES-1];
      end
    end

    // Reset to the pin's idle level, so release of reset is not an edge
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        stage <= {SYNC_STAGES{PIN_IDLE[p]}};
        clean <= PIN_IDLE[p];
      end else begin
        stage <= next_stage;
        clean <= next_clean;
      end
    end

    assign pin_clean[p] = clean;
  end

  // Filtered levels by name; only these are read past the synchronisers
  assign vr_q = pin_clean[PIN_RETRACE];
  assign da_q = pin_clean[PIN_ACTIVE];
  assign sw_q = pin_clean[PIN_SWITCH];
  assign pen_q = pin_clean[PIN_PEN];

  // The address is decoded in full, so aliases of these ports elsewhere in
  // the I/O space are ignored. A strobe is taken at the rising edge on which
  // it stands; the host holds address and data for that whole cycle.
  // Write decode; written data is ignored on the two latch strobe ports
  logic wr_index, wr_data, wr_mode, wr_colour, wr_status, wr_clear, wr_set;
  assign wr_index = io_wr && (io_addr == PORT_TC_INDEX);
  assign wr_data = io_wr && (io_addr == PORT_TC_DATA);
  assign wr_mode = io_wr && (io_addr == PORT_MODE);
  assign wr_colour = io_wr && (io_addr == PORT_COLOUR);
  assign wr_status = io_wr && (io_addr == PORT_STATUS);
  assign wr_clear = io_wr && (io_addr == PORT_PEN_CLEAR);
  assign wr_set = io_wr && (io_addr == PORT_PEN_SET);

  // Previous filtered pen level for the rising-edge detector; it resets to
  // the pen's idle level so the first edge after reset is a real one
  logic pen_prev;
  logic next_pen_prev;
  logic pen_edge;

  always_comb begin
    next_pen_prev = pen_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pen_prev <= PIN_IDLE[PIN_PEN];
    end else begin
      pen_prev <= next_pen_prev;
    end
  end

  // Only a rise counts; a pen held on the screen does not refire the latch
  assign pen_edge = pen_q && !pen_prev;

  // Register state. Mode, colour and array index are write-only bytes kept
  // here for the outputs. The index port keeps only the bits that select one
  // of the controller's registers; numbers past the last one are passed on
  // unchanged and the controller decides what to do with them.
  logic [TC_INDEX_W-1:0] next_tc_index;
  logic next_tc_write;
  logic [7:0] next_tc_wdata, mode, next_mode, colour, next_colour;
  logic [7:0] next_array_index, next_io_rdata;
  logic pen_latch, next_pen_latch, next_io_rdata_valid;

  // Next values for the register group; by default every byte holds
  always_comb begin
    next_tc_index = tc_index;
    next_tc_write = 1'b0;
    next_tc_wdata = tc_wdata;
    next_mode = mode;
    next_colour = colour;
    next_array_index = array_index;
    next_pen_latch = pen_latch;
    next_io_rdata = io_rdata;
    next_io_rdata_valid = 1'b0;
    if (wr_index) begin
      next_tc_index = io_wdata[TC_INDEX_W-1:0];
    end
    // The controller sees a one-cycle write pulse with the byte beside it;
    // the index in force at that moment picks the register it lands in.
    if (wr_data) begin
      next_tc_write = 1'b1;
      next_tc_wdata = io_wdata;
    end
    // Mode and colour bytes are kept whole; bits above the defined fields
    // are stored but drive nothing.
    if (wr_mode) begin
      next_mode = io_wdata;
    end
    if (wr_colour) begin
      next_colour = io_wdata;
    end
    if (wr_status) begin
      next_array_index = io_wdata;
    end
    // Set beats clear, so a pen edge in the clearing cycle is kept.
    // A set latch stays set, and the controller captures no new position,
    // until software writes the clear port.
    if (wr_clear) begin
      next_pen_latch = 1'b0;
    end
    if (wr_set || pen_edge) begin
      next_pen_latch = 1'b1;
    end
    // Read data is registered and stays until the next read, so a slow host
    // may look at it late; the valid pulse marks the cycle it was loaded.
    // Only the status port reads; every other port returns zero
    if (io_rd) begin
      next_io_rdata_valid = 1'b1;
      next_io_rdata = RESET_BYTE;
      if (io_addr == PORT_STATUS) begin
        next_io_rdata = STATUS_RESERVED;
        next_io_rdata[STAT_VRETRACE] = vr_q;
        next_io_rdata[STAT_PEN_SW] = sw_q;
        next_io_rdata[STAT_PEN_TRIG] = pen_latch;
        next_io_rdata[STAT_INACTIVE] = !da_q;
      end
    end
  end

  // Register flops only; every next value is worked out above
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tc_index <= '0;
      tc_write <= 1'b0;
      tc_wdata <= RESET_BYTE;
      mode <= RESET_BYTE;
      colour <= RESET_BYTE;
      array_index <= RESET_BYTE;
      pen_latch <= 1'b0;
      io_rdata <= RESET_BYTE;
      io_rdata_valid <= 1'b0;
    end else begin
      tc_index <= next_tc_index;
      tc_write <= next_tc_write;
      tc_wdata <= next_tc_wdata;
      mode <= next_mode;
      colour <= next_colour;
      array_index <= next_array_index;
      pen_latch <= next_pen_latch;
      io_rdata <= next_io_rdata;
      io_rdata_valid <= next_io_rdata_valid;
    end
  end

  // Field outputs: next values picked from the stored bytes. The extra flop
  // keeps every output on a flop, at the cost of one more cycle between the
  // host write and the pixel pipeline seeing the new mode.
  logic next_pen_strobe;
  logic next_attr_blink_select;
  logic next_wide_graphics_select;
  logic next_display_output_on;
  logic next_mono_colour_select;
  logic next_graphics_mode_select;
  logic next_pixel_clock_speed_select;
  logic next_palette_set_select;
  logic next_back_fore_intensity;
  logic next_border_intensity_select;
  logic next_border_red_select;
  logic next_border_green_select;
  logic next_border_blue_select;

  always_comb begin
    next_pen_strobe = pen_latch;
    next_attr_blink_select = mode[MODE_BLINK];
    next_wide_graphics_select = mode[MODE_WIDE];
    next_display_output_on = mode[MODE_VIDEO_ON];
    next_mono_colour_select = mode[MODE_MONO];
    next_graphics_mode_select = mode[MODE_GRAPHICS];
    next_pixel_clock_speed_select = mode[MODE_PIXEL_CLOCK];
    next_palette_set_select = colour[COL_PALETTE];
    next_back_fore_intensity = colour[COL_BACK_INT];
    next_border_intensity_select = colour[COL_INTENSITY];
    next_border_red_select = colour[COL_RED];
    next_border_green_select = colour[COL_GREEN];
    next_border_blue_select = colour[COL_BLUE];
  end

  // Mode and colour fields registered again so outputs come from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pen_strobe <= 1'b0;
      attr_blink_select <= 1'b0;
      wide_graphics_select <= 1'b0;
      display_output_on <= 1'b0;
      mono_colour_select <= 1'b0;
      graphics_mode_select <= 1'b0;
      pixel_clock_speed_select <= 1'b0;
      palette_set_select <= 1'b0;
      back_fore_intensity <= 1'b0;
      border_intensity_select <= 1'b0;
      border_red_select <= 1'b0;
      border_green_select <= 1'b0;
      border_blue_select <= 1'b0;
    end else begin
      pen_strobe <= next_pen_strobe;
      attr_blink_select <= next_attr_blink_select;
      wide_graphics_select <= next_wide_graphics_select;
      display_output_on <= next_display_output_on;
      mono_colour_select <= next_mono_colour_select;
      graphics_mode_select <= next_graphics_mode_select;
      pixel_clock_speed_select <= next_pixel_clock_speed_select;
      palette_set_select <= next_palette_set_select;
      back_fore_intensity <= next_back_fore_intensity;
      border_intensity_select <= next_border_intensity_select;
      border_red_select <= next_border_red_select;
      border_green_select <= next_border_green_select;
      border_blue_select <= next_border_blue_select;
    end
  end

endmodule

`default_nettype wire

// ==== tb/video_io_props.sv ====
// Port-level checker for the video host I/O registers.
// Assumes one clock, mclk, and async active-high rst.
`timescale 1ns/10ps
`default_nettype none
module video_io_props
  import video_io_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  input wire logic vretrace_in,
  input wire logic [TC_INDEX_W-1:0] tc_index,
  input wire logic tc_write,
  input wire logic [7:0] tc_wdata,
  input wire logic pen_strobe,
  input wire logic [7:0] array_index,
  input wire logic display_output_on
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  tc_write_pulse_a:
    assert property (io_wr && io_addr == PORT_TC_DATA |=> tc_write && tc_wdata == $past(io_wdata))
    else $error("data byte not passed on");
  tc_write_cause_a:
    assert property (tc_write |-> $past(io_wr) && $past(io_addr) == PORT_TC_DATA)
    else $error("stray timing write");
  index_store_a:
    assert property (io_wr && io_addr == PORT_TC_INDEX && io_wdata < 8'h12
      |=> tc_index == $past(io_wdata[4:0])) else $error("index not stored");
  status_retrace_a:
    assert property ((!$changed(vretrace_in))[*6] ##0 io_rd && io_addr == PORT_STATUS
      |=> io_rdata_valid && io_rdata[7:4] == 4'hf && io_rdata[3] == $past(vretrace_in))
    else $error("retrace bit wrong");
  other_read_zero_a:
    assert property (io_rd && io_addr != PORT_STATUS |=> io_rdata == 8'h00)
    else $error("write-only port read back");
  video_on_a:
    assert property (io_wr && io_addr == PORT_MODE
      |-> ##2 display_output_on == $past(io_wdata[MODE_VIDEO_ON], 2)) else $error("video enable");
  pen_set_a:
    assert property (io_wr && io_addr == PORT_PEN_SET |-> ##[1:3] pen_strobe)
    else $error("pen set lost");
  array_index_a:
    assert property (io_wr && io_addr == PORT_STATUS ##1 !io_wr
      |=> array_index == $past(io_wdata, 2)) else $error("array index");
endmodule
bind video_host_io_registers video_io_props video_io_props_inst (.mclk(mclk), .rst(rst),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
  .io_rdata_valid(io_rdata_valid), .vretrace_in(vretrace_in), .tc_index(tc_index),
  .tc_write(tc_write), .tc_wdata(tc_wdata), .pen_strobe(pen_strobe),
  .array_index(array_index), .display_output_on(display_output_on));
`default_nettype wire

// ==== tb/host_bus_model.sv ====
// Host processor model driving the I/O bus.
// Assumes strobes change at falling mclk and stand one cycle.
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
  import video_io_pkg::*;
(
  input wire logic mclk,
  input wire logic io_rdata_valid,
  input wire logic [7:0] io_rdata,
  output logic [ADDR_W-1:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd
);
  // Idle bus; address inverted once released, and data too after a write
  initial begin
    io_addr = '0;
    io_wdata = '0;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  // A read that never answers returns unknown, so it cannot match
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    // The valid pulse stands only this cycle, so take the data before release
    d = io_rdata_valid ? io_rdata : 8'hxx;
    io_rd = 1'b0;
    io_addr = ~a;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_video_host_io_registers.sv ====
// Self-checking bench for the video host I/O registers.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_video_host_io_registers;
  import video_io_pkg::*;
  logic mclk = 0, rst = 1, vr = 0, act = 0, sw_n = 1, pen = 0, wr, rd, valid, tcw, pstr;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, rd_v, tcd, aidx, seed = 8'h2d;
  logic [4:0] idx;
  wire [11:0] f;
  int miscompares, samples_checked, cyc, exp_mode, tcq[$];
  video_host_io_registers video_host_io_registers_inst (.mclk(mclk), .rst(rst), .io_addr(addr),
    .io_wdata(wdata), .io_wr(wr), .io_rd(rd), .io_rdata(rdata), .io_rdata_valid(valid),
    .vretrace_in(vr), .display_active_in(act), .pen_switch_n(sw_n), .pen_in(pen),
    .tc_index(idx), .tc_write(tcw), .tc_wdata(tcd), .pen_strobe(pstr), .array_index(aidx),
    .attr_blink_select(f[5]), .wide_graphics_select(f[4]), .display_output_on(f[3]),
    .mono_colour_select(f[2]), .graphics_mode_select(f[1]), .pixel_clock_speed_select(f[0]),
    .palette_set_select(f[11]), .back_fore_intensity(f[10]), .border_intensity_select(f[9]),
    .border_red_select(f[8]), .border_green_select(f[7]), .border_blue_select(f[6]));
  host_bus_model host_bus_model_inst (.mclk(mclk), .io_rdata_valid(valid), .io_rdata(rdata),
    .io_addr(addr), .io_wdata(wdata), .io_wr(wr), .io_rd(rd));
  initial forever #4 mclk = ~mclk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      $display("unexpected %s exp %h got %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short; the whole run needs well under 1000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      print_verdict;
    end
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst = 0;
    // Every timing register, index then random data back to back
    for (int i = 0; i < TC_REG_COUNT; i++) begin
      seed = lfsr(seed);
      tcq.push_back(seed);
      host_bus_model_inst.wr(PORT_TC_INDEX, 8'(i));
      host_bus_model_inst.wr(PORT_TC_DATA, seed);
      // The task returns while the one-cycle write pulse still stands
      chk("tc index", {2'h0, tcw, idx}, {3'h1, 5'(i)});
      chk("tc data", tcd, 8'(tcq.pop_front()));
    end
    $display("timing port test done");
    // Each mode bit alone with the colour byte its inverse, then random; an unmapped write must not disturb them
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      exp_mode = (k < 6) ? (1 << k) : seed;
      host_bus_model_inst.wr(PORT_MODE, 8'(exp_mode));
      host_bus_model_inst.wr(PORT_COLOUR, ~8'(exp_mode));
      host_bus_model_inst.wr(10'h3d0, 8'hff);
      @(negedge mclk); // Let a stray effect of the unmapped write reach the fields
      chk("mode", {2'h0, f[5:0]}, 8'(exp_mode) & 8'h3f);
      chk("colour", {2'h0, f[11:6]}, ~8'(exp_mode) & 8'h3f);
    end
    $display("mode test done");
    for (int k = 0; k < 8; k++) begin
      {vr, act, sw_n} = 3'(k);
      repeat (8) @(negedge mclk);
      host_bus_model_inst.rd(PORT_STATUS, rd_v);
      chk("status", rd_v, {4'hf, vr, sw_n, 1'b0, ~act});
    end
    host_bus_model_inst.rd(PORT_TC_DATA, rd_v);
    chk("data readback", rd_v, 8'h00);
    $display("status test done");
    // Pen edge sets, 3db clears before the next capture, 3dc sets
    host_bus_model_inst.wr(PORT_PEN_CLEAR, seed);
    pen = 1;
    repeat (8) @(negedge mclk);
    chk("pen strobe", {7'h0, pstr}, 8'h01);
    host_bus_model_inst.rd(PORT_STATUS, rd_v);
    chk("latch set", rd_v & 8'h02, 8'h02);
    pen = 0;
    host_bus_model_inst.wr(PORT_PEN_CLEAR, lfsr(seed));
    host_bus_model_inst.rd(PORT_STATUS, rd_v);
    chk("latch clear", rd_v & 8'h02, 8'h00);
    host_bus_model_inst.wr(PORT_PEN_SET, seed);
    host_bus_model_inst.rd(PORT_STATUS, rd_v);
    chk("latch write set", rd_v & 8'h02, 8'h02);
    host_bus_model_inst.wr(PORT_STATUS, seed);
    repeat (2) @(negedge mclk);
    chk("array index", aidx, seed);
    $display("pen and array test done");
    // Reset in mid-run clears every field and the pen latch at once
    rst = 1;
    @(negedge mclk);
    chk("reset fields", f[7:0], 8'h00);
    chk("reset pen", {3'h0, pstr, f[11:8]}, 8'h00);
    rst = 0;
    $display("reset test done");
    print_verdict;
  end
endmodule
`default_nettype wire
